// ==== design/pdc_defs.vh ====
/*
  Constants for the phase delay calibration and power sign block:
  register addresses, field positions, reset values and quantity codes.
  Assumes inclusion by bare name from the design files only.
*/
`ifndef PDC_DEFS_VH
`define PDC_DEFS_VH

// ==========================================================================
// Register addresses
`define PDC_ADDR_W            16
`define PDC_ADDR_PHA_CAL      16'hE614
`define PDC_ADDR_PHB_CAL      16'hE615
`define PDC_ADDR_PHC_CAL      16'hE616
`define PDC_ADDR_SIGN_STAT    16'hE617
`define PDC_ADDR_ACC_MODE     16'hE6F0
`define PDC_ADDR_COMP_MODE    16'hE6F1
`define PDC_ADDR_PULSE_MODE   16'hE6F2

// ==========================================================================
// Delay calibration fields
`define PDC_LOW_MSB           4
`define PDC_LOW_LSB           0
`define PDC_MID_MSB           6
`define PDC_MID_LSB           5
`define PDC_HIGH_MSB          8
`define PDC_HIGH_LSB          7
`define PDC_SEL_BIT           9
`define PDC_CAL_MASK          16'h03FF
`define PDC_CAL_RESET         16'h0000
`define PDC_MID_VOLT_MAX      2'h1
`define PDC_HIGH_VOLT_VAL     2'h0
`define PDC_MID_SHIFT         5
`define PDC_HIGH_SHIFT        7

// ==========================================================================
// Mode registers
`define PDC_ACC_ACT_SEL_BIT   6
`define PDC_ACC_REACT_SEL_BIT 7
`define PDC_ACC_MASK          16'h00C0
`define PDC_PATH1_LSB         0
`define PDC_PATH2_LSB         3
`define PDC_PATH3_LSB         6
`define PDC_PATH_MASK         16'h01FF
`define PDC_MODE_RESET        16'h0000
`define PDC_COMP_RESET        16'h01FF

// ==========================================================================
// Quantity codes
`define PDC_Q_ACT_TOT         3'h0
`define PDC_Q_REACT_TOT       3'h1
`define PDC_Q_APPARENT        3'h2
`define PDC_Q_ACT_FUND        3'h3
`define PDC_Q_REACT_FUND      3'h4

// ==========================================================================
// Sign status bits
`define PDC_ST_ACT_A          0
`define PDC_ST_ACT_B          1
`define PDC_ST_ACT_C          2
`define PDC_ST_SUM1           3
`define PDC_ST_REACT_A        4
`define PDC_ST_REACT_B        5
`define PDC_ST_REACT_C        6
`define PDC_ST_SUM2           7
`define PDC_ST_SUM3           8
`define PDC_ST_MASK           16'h01FF

`endif

// ==== design/pdc_phase_delay.v ====
/*
  One phase of the calibration delay: a sample shift line holding
  current and voltage sample pairs, delaying the selected channel.
  Assumes push comes from same-clock logic and delay is already limited.
*/
`timescale 1ns/1ps

module pdc_phase_delay #(
  parameter SW = 24,
  parameter AW = 9
) (
  input  wire          core_clk,
  input  wire          reset_n,
  input  wire          push,
  input  wire [SW-1:0] cur_in,
  input  wire [SW-1:0] volt_in,
  input  wire [AW-1:0] delay,
  input  wire          comp_volt,
  output wire [SW-1:0] cur_out,
  output wire [SW-1:0] volt_out
);

  reg  [2*SW-1:0] mem [0:(1<<AW)-1];
  reg  [AW-1:0]   wp_ff;
  reg  [AW:0]     fill_ff;
  wire [AW-1:0]   rp;
  wire [2*SW-1:0] old_pair;
  wire            have_old;
  wire [SW-1:0]   dly_cur;
  wire [SW-1:0]   dly_volt;

  // ========================================================================
  // Write side
  always @(posedge core_clk)
  begin
    if (push)
    begin
      mem[wp_ff] <= {cur_in, volt_in};
    end
  end

  always @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      wp_ff   <= {AW{1'b0}};
      fill_ff <= {(AW+1){1'b0}};
    end
    else if (push)
    begin
      wp_ff <= wp_ff + {{(AW-1){1'b0}}, 1'b1};
      if (fill_ff != (1 << AW))
      begin
        fill_ff <= fill_ff + {{AW{1'b0}}, 1'b1};
      end
    end
  end

  // ========================================================================
  // Read side
  assign rp       = wp_ff - delay;
  assign old_pair = mem[rp];
  assign have_old = ({1'b0, delay} <= fill_ff);
  assign dly_cur  = (delay == {AW{1'b0}}) ? cur_in :
                    (have_old ? old_pair[2*SW-1:SW] : {SW{1'b0}});
  assign dly_volt = (delay == {AW{1'b0}}) ? volt_in :
                    (have_old ? old_pair[SW-1:0] : {SW{1'b0}});

  // Uncompensated channel passes through undelayed
  assign cur_out  = comp_volt ? cur_in : dly_cur;
  assign volt_out = comp_volt ? dly_volt : volt_in;

endmodule

// ==== design/pdc_top.v ====
/*
  Per-phase delay calibration on the current or voltage sample stream,
  and the power sign status word for phases and pulse output paths.
  Assumes sample and power inputs come from logic on core_clk and a
  register master that follows the one-cycle strobe protocol.
*/
`timescale 1ns/1ps
`include "pdc_defs.vh"

// Notes on behaviour
// - The low five-bit delay field delays the compensated channel by 0 to 31 samples.
// - The middle two-bit field adds thirty-two samples per step to the low field.
// - With current compensation every middle value from zero to three is used.
// - With voltage compensation a middle value above one is taken as one.
// - With current compensation the upper field adds 128 samples per step.
// - With voltage compensation the upper field is taken as zero.
// - Select bit zero delays the current channel, one delays the voltage channel.
// - The top six bits of each calibration register do nothing and read zero.
// - Status bits 0 to 2 give the active power sign of phases A to C, total or fundamental by mode bit 6.
// - Status bits 4 to 6 give the reactive power sign of phases A to C, total or fundamental by mode bit 7.
// - Status bit 3 is set when the summed power of the first pulse path is negative.
// - Status bit 7 is set when the summed power of the second pulse path is negative.
// - Status bit 8 is set when the summed power of the third pulse path is negative.
// - The upper seven status bits always read zero.
// - The path quantity code picks total active, total reactive, apparent, fundamental active or reactive.
module pdc_top #(
  parameter SW = 24,
  parameter PW = 32,
  parameter AW = 9
) (
  input  wire                core_clk,
  input  wire                reset_n,
  input  wire [15:0]         reg_addr,
  input  wire [15:0]         reg_wdata,
  input  wire                reg_wr,
  input  wire                reg_rd,
  output reg  [15:0]         reg_rdata_ff,
  input  wire                in_valid,
  output reg                 in_ready_ff,
  input  wire [3*SW-1:0]     in_cur,
  input  wire [3*SW-1:0]     in_volt,
  output reg                 out_valid_ff,
  input  wire                out_ready,
  output reg  [3*SW-1:0]     out_cur_ff,
  output reg  [3*SW-1:0]     out_volt_ff,
  input  wire [3*PW-1:0]     act_tot,
  input  wire [3*PW-1:0]     act_fund,
  input  wire [3*PW-1:0]     react_tot,
  input  wire [3*PW-1:0]     react_fund,
  input  wire [3*PW-1:0]     apparent,
  output reg  [15:0]         power_sign_ff
);

  // ========================================================================
  // Registers
  reg  [15:0]     cal_a_ff;
  reg  [15:0]     cal_b_ff;
  reg  [15:0]     cal_c_ff;
  reg  [15:0]     acc_mode_ff;
  reg  [15:0]     comp_mode_ff;
  reg  [15:0]     pulse_mode_ff;
  reg  [15:0]     nxt_rdata;
  reg  [15:0]     nxt_sign;

  // Data path
  wire            push;
  wire            pop;
  wire [3*SW-1:0] dly_cur;
  wire [3*SW-1:0] dly_volt;
  wire [AW-1:0]   delay_a;
  wire [AW-1:0]   delay_b;
  wire [AW-1:0]   delay_c;
  reg  [1:0]      cnt_ff;
  reg  [1:0]      nxt_cnt;
  reg  [3*SW-1:0] spare_cur_ff;
  reg  [3*SW-1:0] spare_volt_ff;

  // ========================================================================
  // Effective delay from a calibration word
  function [AW-1:0] eff_delay;
    input [15:0] cal;
    reg   [1:0]  mid;
    reg   [1:0]  high;
    reg   [4:0]  low;
    begin
      low  = cal[`PDC_LOW_MSB:`PDC_LOW_LSB];
      mid  = cal[`PDC_MID_MSB:`PDC_MID_LSB];
      high = cal[`PDC_HIGH_MSB:`PDC_HIGH_LSB];
      if (cal[`PDC_SEL_BIT])
      begin
        if (mid > `PDC_MID_VOLT_MAX)
        begin
          mid = `PDC_MID_VOLT_MAX;
        end
        high = `PDC_HIGH_VOLT_VAL;
      end
      eff_delay = ({{(AW-2){1'b0}}, high} << `PDC_HIGH_SHIFT)
                + ({{(AW-2){1'b0}}, mid} << `PDC_MID_SHIFT)
                + {{(AW-5){1'b0}}, low};
    end
  endfunction

  // ========================================================================
  // One phase term of a pulse path, extended by one bit
  function [PW:0] path_term;
    input [2:0] q;
    input [1:0] ph;
    reg   [PW-1:0] v;
    begin
      v = act_tot[ph*PW +: PW];
      path_term = {v[PW-1], v};
      case (q)
        `PDC_Q_ACT_TOT:
        begin
          v = act_tot[ph*PW +: PW];
          path_term = {v[PW-1], v};
        end
        `PDC_Q_REACT_TOT:
        begin
          v = react_tot[ph*PW +: PW];
          path_term = {v[PW-1], v};
        end
        `PDC_Q_APPARENT:
        begin
          v = apparent[ph*PW +: PW];
          path_term = {1'b0, v};
        end
        `PDC_Q_ACT_FUND:
        begin
          v = act_fund[ph*PW +: PW];
          path_term = {v[PW-1], v};
        end
        `PDC_Q_REACT_FUND:
        begin
          v = react_fund[ph*PW +: PW];
          path_term = {v[PW-1], v};
        end
        default:
        begin
          v = act_tot[ph*PW +: PW];
          path_term = {v[PW-1], v};
        end
      endcase
    end
  endfunction

  // ========================================================================
  // Sign of the sum of included phases in one pulse path
  function path_neg;
    input [2:0] incl;
    input [2:0] q;
    reg   [PW+2:0] s;
    reg   [PW:0]   t;
    integer        k;
    begin
      s = {(PW+3){1'b0}};
      for (k = 0; k < 3; k = k + 1)
      begin
        t = path_term(q, k[1:0]);
        if (incl[k])
        begin
          s = s + {{2{t[PW]}}, t};
        end
      end
      path_neg = s[PW+2];
    end
  endfunction

  // ========================================================================
  // Register writes
  always @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      cal_a_ff      <= `PDC_CAL_RESET;
      cal_b_ff      <= `PDC_CAL_RESET;
      cal_c_ff      <= `PDC_CAL_RESET;
      acc_mode_ff   <= `PDC_MODE_RESET;
      comp_mode_ff  <= `PDC_COMP_RESET;
      pulse_mode_ff <= `PDC_MODE_RESET;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `PDC_ADDR_PHA_CAL:    cal_a_ff      <= reg_wdata & `PDC_CAL_MASK;
        `PDC_ADDR_PHB_CAL:    cal_b_ff      <= reg_wdata & `PDC_CAL_MASK;
        `PDC_ADDR_PHC_CAL:    cal_c_ff      <= reg_wdata & `PDC_CAL_MASK;
        `PDC_ADDR_ACC_MODE:   acc_mode_ff   <= reg_wdata & `PDC_ACC_MASK;
        `PDC_ADDR_COMP_MODE:  comp_mode_ff  <= reg_wdata & `PDC_PATH_MASK;
        `PDC_ADDR_PULSE_MODE: pulse_mode_ff <= reg_wdata & `PDC_PATH_MASK;
        default:
        begin
          cal_a_ff <= cal_a_ff;
        end
      endcase
    end
  end

  // ========================================================================
  // Register reads, data valid in the cycle after the strobe only
  always @*
  begin
    nxt_rdata = 16'h0000;
    if (reg_rd)
    begin
      case (reg_addr)
        `PDC_ADDR_PHA_CAL:    nxt_rdata = cal_a_ff;
        `PDC_ADDR_PHB_CAL:    nxt_rdata = cal_b_ff;
        `PDC_ADDR_PHC_CAL:    nxt_rdata = cal_c_ff;
        `PDC_ADDR_SIGN_STAT:  nxt_rdata = power_sign_ff;
        `PDC_ADDR_ACC_MODE:   nxt_rdata = acc_mode_ff;
        `PDC_ADDR_COMP_MODE:  nxt_rdata = comp_mode_ff;
        `PDC_ADDR_PULSE_MODE: nxt_rdata = pulse_mode_ff;
        default:              nxt_rdata = 16'h0000;
      endcase
    end
  end

  always @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      reg_rdata_ff <= 16'h0000;
    end
    else
    begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // ========================================================================
  // Power sign status
  // Path functions read the power inputs, so every input is listed by name
  always @(acc_mode_ff or comp_mode_ff or pulse_mode_ff or
           act_tot or act_fund or react_tot or react_fund or apparent)
  begin
    nxt_sign = 16'h0000;
    if (acc_mode_ff[`PDC_ACC_ACT_SEL_BIT])
    begin
      nxt_sign[`PDC_ST_ACT_A] = act_fund[PW-1];
      nxt_sign[`PDC_ST_ACT_B] = act_fund[2*PW-1];
      nxt_sign[`PDC_ST_ACT_C] = act_fund[3*PW-1];
    end
    else
    begin
      nxt_sign[`PDC_ST_ACT_A] = act_tot[PW-1];
      nxt_sign[`PDC_ST_ACT_B] = act_tot[2*PW-1];
      nxt_sign[`PDC_ST_ACT_C] = act_tot[3*PW-1];
    end
    if (acc_mode_ff[`PDC_ACC_REACT_SEL_BIT])
    begin
      nxt_sign[`PDC_ST_REACT_A] = react_fund[PW-1];
      nxt_sign[`PDC_ST_REACT_B] = react_fund[2*PW-1];
      nxt_sign[`PDC_ST_REACT_C] = react_fund[3*PW-1];
    end
    else
    begin
      nxt_sign[`PDC_ST_REACT_A] = react_tot[PW-1];
      nxt_sign[`PDC_ST_REACT_B] = react_tot[2*PW-1];
      nxt_sign[`PDC_ST_REACT_C] = react_tot[3*PW-1];
    end
    nxt_sign[`PDC_ST_SUM1] = path_neg(comp_mode_ff[`PDC_PATH1_LSB +: 3],
                                      pulse_mode_ff[`PDC_PATH1_LSB +: 3]);
    nxt_sign[`PDC_ST_SUM2] = path_neg(comp_mode_ff[`PDC_PATH2_LSB +: 3],
                                      pulse_mode_ff[`PDC_PATH2_LSB +: 3]);
    nxt_sign[`PDC_ST_SUM3] = path_neg(comp_mode_ff[`PDC_PATH3_LSB +: 3],
                                      pulse_mode_ff[`PDC_PATH3_LSB +: 3]);
  end

  always @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      power_sign_ff <= 16'h0000;
    end
    else
    begin
      power_sign_ff <= nxt_sign & `PDC_ST_MASK;
    end
  end

  // ========================================================================
  // Phase delay lines
  assign push    = in_valid & in_ready_ff;
  assign pop     = out_valid_ff & out_ready;
  assign delay_a = eff_delay(cal_a_ff);
  assign delay_b = eff_delay(cal_b_ff);
  assign delay_c = eff_delay(cal_c_ff);

  pdc_phase_delay #(
    .SW (SW),
    .AW (AW)
  ) u_delay_a (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .push      (push),
    .cur_in    (in_cur[0 +: SW]),
    .volt_in   (in_volt[0 +: SW]),
    .delay     (delay_a),
    .comp_volt (cal_a_ff[`PDC_SEL_BIT]),
    .cur_out   (dly_cur[0 +: SW]),
    .volt_out  (dly_volt[0 +: SW])
  );

  pdc_phase_delay #(
    .SW (SW),
    .AW (AW)
  ) u_delay_b (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .push      (push),
    .cur_in    (in_cur[SW +: SW]),
    .volt_in   (in_volt[SW +: SW]),
    .delay     (delay_b),
    .comp_volt (cal_b_ff[`PDC_SEL_BIT]),
    .cur_out   (dly_cur[SW +: SW]),
    .volt_out  (dly_volt[SW +: SW])
  );

  pdc_phase_delay #(
    .SW (SW),
    .AW (AW)
  ) u_delay_c (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .push      (push),
    .cur_in    (in_cur[2*SW +: SW]),
    .volt_in   (in_volt[2*SW +: SW]),
    .delay     (delay_c),
    .comp_volt (cal_c_ff[`PDC_SEL_BIT]),
    .cur_out   (dly_cur[2*SW +: SW]),
    .volt_out  (dly_volt[2*SW +: SW])
  );

  // ========================================================================
  // Two-entry output buffer
  always @*
  begin
    nxt_cnt = cnt_ff;
    if (push && !pop)
    begin
      nxt_cnt = cnt_ff + 2'h1;
    end
    else if (pop && !push)
    begin
      nxt_cnt = cnt_ff - 2'h1;
    end
  end

  always @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      cnt_ff        <= 2'h0;
      in_ready_ff   <= 1'b1;
      out_valid_ff  <= 1'b0;
      out_cur_ff    <= {(3*SW){1'b0}};
      out_volt_ff   <= {(3*SW){1'b0}};
      spare_cur_ff  <= {(3*SW){1'b0}};
      spare_volt_ff <= {(3*SW){1'b0}};
    end
    else
    begin
      cnt_ff       <= nxt_cnt;
      in_ready_ff  <= (nxt_cnt != 2'h2);
      out_valid_ff <= (nxt_cnt != 2'h0);
      if (pop)
      begin
        if (cnt_ff == 2'h2)
        begin
          out_cur_ff  <= spare_cur_ff;
          out_volt_ff <= spare_volt_ff;
          if (push)
          begin
            spare_cur_ff  <= dly_cur;
            spare_volt_ff <= dly_volt;
          end
        end
        else if (push)
        begin
          out_cur_ff  <= dly_cur;
          out_volt_ff <= dly_volt;
        end
      end
      else if (push)
      begin
        if (cnt_ff == 2'h0)
        begin
          out_cur_ff  <= dly_cur;
          out_volt_ff <= dly_volt;
        end
        else
        begin
          spare_cur_ff  <= dly_cur;
          spare_volt_ff <= dly_volt;
        end
      end
    end
  end

endmodule

// ==== verif/pdc_top_props.sv ====
/*
  Checker for pdc_top: register read timing, masks, sign status and stream handshake.
  Assumes it is bound to pdc_top and sampled on core_clk.
*/
`timescale 1ns/1ps

module pdc_top_props #(
  parameter SW = 24,
  parameter PW = 32,
  parameter AW = 9
) (
  input logic [15:0]     reg_addr,
  input logic [15:0]     reg_wdata,
  input logic            core_clk,
  input logic            reset_n,
  input logic            reg_wr,
  input logic            reg_rd,
  input logic [15:0]     reg_rdata_ff,
  input logic            in_valid,
  input logic            in_ready_ff,
  input logic            out_valid_ff,
  input logic            out_ready,
  input logic [3*SW-1:0] out_cur_ff,
  input logic [3*SW-1:0] out_volt_ff,
  input logic [3*PW-1:0] act_tot,
  input logic [3*PW-1:0] act_fund,
  input logic [3*PW-1:0] react_tot,
  input logic [3*PW-1:0] react_fund,
  input logic [15:0]     power_sign_ff
);
  reg [1:0] acc_sel_ff;

  // ==========================================================================
  // Shadow of the accumulation mode bits
  always @(posedge core_clk)
  begin
    if (!reset_n)
      acc_sel_ff <= 2'h0;
    else if (reg_wr && reg_addr == 16'hE6F0)
      acc_sel_ff <= reg_wdata[7:6];
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // ==========================================================================
  // Assertions
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata_ff == 16'h0000)
    else $error("read data not zero outside a read");
  AST_CAL_MASK: assert property ($past(reg_rd) && $past(reg_addr) >= 16'hE614 && $past(reg_addr) <= 16'hE616
    |-> reg_rdata_ff[15:10] == 6'h00) else $error("calibration upper bits not zero");
  AST_WR_RD: assert property (reg_wr && reg_addr == 16'hE614 ##1 reg_rd && reg_addr == 16'hE614
    |=> reg_rdata_ff == ($past(reg_wdata, 2) & 16'h03FF)) else $error("calibration readback wrong");
  AST_STATUS_UPPER: assert property (power_sign_ff[15:9] == 7'h00)
    else $error("status upper bits not zero");
  AST_STATUS_READ: assert property ($past(reg_rd) && $past(reg_addr) == 16'hE617
    |-> reg_rdata_ff == $past(power_sign_ff)) else $error("status read differs from status word");
  AST_ACT_A: assert property (power_sign_ff[0] == $past(acc_sel_ff[0] ? act_fund[PW-1] : act_tot[PW-1]))
    else $error("phase A active sign wrong");
  AST_REACT_C: assert property (power_sign_ff[6] == $past(acc_sel_ff[1] ? react_fund[3*PW-1] : react_tot[3*PW-1]))
    else $error("phase C reactive sign wrong");
  AST_HOLD: assert property (out_valid_ff && !out_ready
    |=> out_valid_ff && $stable(out_cur_ff) && $stable(out_volt_ff)) else $error("output changed under stall");
  AST_PUSH_OUT: assert property (in_valid && in_ready_ff && !out_valid_ff |=> out_valid_ff)
    else $error("accepted sample not presented");
  AST_FULL: assert property (!in_ready_ff |-> out_valid_ff)
    else $error("input refused while output empty");

  COV_STALL: cover property (out_valid_ff && !out_ready);
  COV_FULL: cover property (!in_ready_ff);
  COV_STATUS: cover property ($past(reg_rd) && $past(reg_addr) == 16'hE617 && reg_rdata_ff != 16'h0000);
endmodule

bind pdc_top pdc_top_props #(.SW(SW), .PW(PW), .AW(AW)) pdc_top_props_inst (
  .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .in_valid(in_valid),
  .in_ready_ff(in_ready_ff), .out_valid_ff(out_valid_ff), .out_ready(out_ready),
  .out_cur_ff(out_cur_ff), .out_volt_ff(out_volt_ff), .act_tot(act_tot), .act_fund(act_fund),
  .react_tot(react_tot), .react_fund(react_fund), .power_sign_ff(power_sign_ff));

// ==== verif/pdc_top_tb.sv ====
/*
  Self-checking bench for pdc_top: registers, delay lines, buffer and sign status.
  Assumes the design sources and the checker are compiled before it.
*/
`timescale 1ns/1ps

module pdc_top_tb;
  localparam [47:0] VX = 48'h800080008000;
  reg          core_clk, reset_n, reg_wr, reg_rd, in_valid, out_ready;
  reg [15:0]   reg_addr, reg_wdata;
  reg [47:0]   in_cur, in_volt, act_tot, act_fund, react_tot, react_fund, apparent;
  wire [15:0]  reg_rdata_ff, power_sign_ff;
  wire         in_ready_ff, out_valid_ff;
  wire [47:0]  out_cur_ff, out_volt_ff;
  integer      err_total, comparisons, s, k, i;
  integer      pv [0:14] = '{-100, 30, 20, 5, 6, -20, 100, 200, 300, 10, -40, 5, -1, 2, 3};
  reg [15:0]   ra [0:7] = '{16'hE614, 16'hE615, 16'hE616, 16'hE617, 16'hE6F0, 16'hE6F1, 16'hE6F2, 16'hE6FF};
  reg [15:0]   rv [0:7] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h01FF, 16'h0000, 16'h0000};

  pdc_top #(.SW(16), .PW(16), .AW(9)) pdc_top_inst (
    .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .in_valid(in_valid),
    .in_ready_ff(in_ready_ff), .in_cur(in_cur), .in_volt(in_volt), .out_valid_ff(out_valid_ff),
    .out_ready(out_ready), .out_cur_ff(out_cur_ff), .out_volt_ff(out_volt_ff), .act_tot(act_tot),
    .act_fund(act_fund), .react_tot(react_tot), .react_fund(react_fund), .apparent(apparent),
    .power_sign_ff(power_sign_ff));

  // ==========================================================================
  // Compare and bus tasks
  task chk16(input [15:0] got, input [15:0] exp);
  begin
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("CHECK FAILED at %0t: word %h expected %h", $time, got, exp);
    end
  end
  endtask

  task chkv(input [47:0] got, input [47:0] exp);
  begin
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("CHECK FAILED at %0t: sample %h expected %h", $time, got, exp);
    end
  end
  endtask

  task wr(input [15:0] a, input [15:0] d, input g);
  begin
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    if (g)
      @(posedge core_clk);
  end
  endtask

  task rd(input [15:0] a, input [15:0] e);
  begin
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk16(reg_rdata_ff, e);
    @(posedge core_clk);
  end
  endtask

  function [47:0] pk(input integer v, input [47:0] m);
  begin
    pk = 48'h000000000000;
    if (v >= 0)
      pk = {v[15:0] + 16'h2000, v[15:0] + 16'h1000, v[15:0]} ^ m;
  end
  endfunction

  task push(input integer v);
    integer n;
  begin
    in_valid <= 1'b1;
    in_cur <= pk(v, 48'h000000000000);
    in_volt <= pk(v, VX);
    @(posedge core_clk);
    for (n = 0; n < 20 && !in_ready_ff; n = n + 1)
      @(posedge core_clk);
    chk16({15'h0000, in_ready_ff}, 16'h0001);
  end
  endtask

  task pop(input [47:0] ec, input [47:0] ev);
    integer n;
    reg     got;
  begin
    in_valid <= 1'b0;
    got = 1'b0;
    for (n = 0; n < 20 && !got; n = n + 1)
    begin
      @(posedge core_clk);
      got = out_valid_ff;
    end
    chk16({15'h0000, got}, 16'h0001);
    chkv(out_cur_ff, ec);
    chkv(out_volt_ff, ev);
  end
  endtask

  task dly(input [15:0] cal, input integer d);
  begin
    for (i = 0; i < 3; i = i + 1)
      wr(16'hE614 + i, cal, 1'b1);
    for (k = 0; k < d + 3; k = k + 1)
    begin
      push(s);
      pop(pk(cal[9] ? s : s - d, 48'h000000000000), pk(cal[9] ? s - d : s, VX));
      s = s + 1;
    end
    $display("delay case %h done, %0d mismatches so far", cal, err_total);
  end
  endtask

  function [47:0] pp(input integer q);
  begin
    pp = {pv[3*q+2][15:0], pv[3*q+1][15:0], pv[3*q][15:0]};
  end
  endfunction

  function [15:0] est(input [15:0] a, input [15:0] cm, input [15:0] pm);
    integer p, j, q, t;
  begin
    est = 16'h0000;
    for (p = 0; p < 3; p = p + 1)
    begin
      est[p] = (a[6] ? pv[9+p] : pv[p]) < 0;
      est[p+4] = (a[7] ? pv[12+p] : pv[3+p]) < 0;
    end
    for (j = 0; j < 3; j = j + 1)
    begin
      q = pm[3*j +: 3];
      if (q > 4)
        q = 0;
      t = 0;
      for (p = 0; p < 3; p = p + 1)
        if (cm[3*j+p])
          t = t + pv[3*q+p];
      est[j == 0 ? 3 : j + 6] = t < 0;
    end
  end
  endfunction

  task pw(input [15:0] a, input [15:0] cm, input [15:0] pm);
  begin
    wr(16'hE6F0, a, 1'b1);
    wr(16'hE6F1, cm, 1'b1);
    wr(16'hE6F2, pm, 1'b1);
    @(posedge core_clk);
    chk16(power_sign_ff, est(a, cm, pm));
    rd(16'hE617, est(a, cm, pm));
  end
  endtask

  task print_verdict;
  begin
    $display("comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask

  // ==========================================================================
  // Clock, watchdog and test sequence
  initial
  begin
    forever #2.5 core_clk = ~core_clk;
  end

  initial
  begin
    #400000;
    err_total = err_total + 1;
    $display("CHECK FAILED at %0t: timeout", $time);
    print_verdict;
  end

  initial
  begin
    core_clk = 1'b0;
    reset_n = 1'b0;
    {reg_wr, reg_rd, in_valid, out_ready} = 4'h1;
    {reg_addr, reg_wdata} = 32'h00000000;
    {in_cur, in_volt, act_tot, act_fund, react_tot, react_fund, apparent} = 336'h0;
    err_total = 0;
    comparisons = 0;
    s = 0;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    for (i = 0; i < 8; i = i + 1)
      rd(ra[i], rv[i]);
    wr(16'hE614, 16'hFFFF, 1'b0);
    rd(16'hE614, 16'h03FF);
    wr(16'hE617, 16'hFFFF, 1'b1);
    rd(16'hE617, 16'h0000);
    $display("register test done, %0d mismatches so far", err_total);
    dly(16'h0000, 0);
    out_ready <= 1'b0;
    push(s);
    push(s + 1);
    in_valid <= 1'b0;
    #1;
    chk16({15'h0000, in_ready_ff}, 16'h0000);
    @(posedge core_clk);
    out_ready <= 1'b1;
    pop(pk(s, 48'h000000000000), pk(s, VX));
    pop(pk(s + 1, 48'h000000000000), pk(s + 1, VX));
    s = s + 2;
    $display("buffer test done, %0d mismatches so far", err_total);
    dly(16'h001F, 31);
    dly(16'h0060, 96);
    dly(16'h0260, 32);
    dly(16'h0380, 0);
    dly(16'h0100, 256);
    dly(16'h0145, 325);
    dly(16'h03BF, 63);
    act_tot <= pp(0);
    react_tot <= pp(1);
    apparent <= pp(2);
    act_fund <= pp(3);
    react_fund <= pp(4);
    for (i = 0; i < 8; i = i + 1)
      pw(i[1] ? 16'h00C0 : 16'h0000, i[0] ? 16'h0111 : 16'h01FF, {7'h00, i[2:0], i[2:0], i[2:0]});
    $display("sign test done, %0d mismatches so far", err_total);
    print_verdict;
  end
endmodule
